// ===== design/pprh_ctrl.sv
// How it works
// - After power-up reset every macrocell register is cleared low.
// - Sleep pin acts as power-down control only when its enable bit is set.
// - While sleep pin is high, macrocell and config registers, pin outputs, enables and array inputs are held.
// - Outputs disabled at sleep entry stay disabled throughout sleep.
// - During sleep the pin, array and bus-write inputs are ignored; bus reads are still answered.
// - Input hold latches keep the last pin levels during sleep.
// - With sleep enabled the sleep pin's array input reads low; rest usable.
// - Each register can be preloaded high or low individually.
// - Preload is accepted only while the high-voltage detect input is high.
// - Per-output slew bit; slow is default and adds one cycle of delay.
// - Once the lock is set, config readback reads zero and preload is refused.
// - The 160-bit user signature stays readable after locking.
`timescale 1ns/1ps
`default_nettype none
`include "pprh_cfg.svh"

module pprh_ctrl #(
    parameter int NUM_MC        = 32,
    parameter int SLEEP_PIN_IDX = 0,
    parameter int POR_CYCLES    = `PPRH_TPR_CYC
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_ce,
    // APB
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [7:0]              i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic [31:0]                  o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr,
    // Device pins and array
    input  wire logic                    i_sleep_hold_pin,
    input  wire logic                    i_preload_hv,
    input  wire logic [NUM_MC-1:0]       i_pin_in,
    input  wire logic [NUM_MC-1:0]       i_mc_d,
    input  wire logic                    i_mc_load,
    input  wire logic [NUM_MC-1:0]       i_oe_req,
    output logic [NUM_MC-1:0]            o_array_in,
    output logic [NUM_MC-1:0]            o_mc_q,
    output logic [NUM_MC-1:0]            o_pin_out,
    output logic [NUM_MC-1:0]            o_pin_oe,
    output logic [NUM_MC-1:0]            o_slew_fast,
    output pprh_pkg::pprh_status_type    o_status
);

    logic                      por_busy;
    logic                      sleep_en_q;
    logic [NUM_MC-1:0]         slew_q;
    logic                      lock_q;
    logic [NUM_MC-1:0]         pl_mask_q;
    logic [31:0]               sig_q [`PPRH_SIG_WORDS];
    logic [NUM_MC-1:0]         in_hold_q;
    logic [NUM_MC-1:0]         slow_q;
    logic [NUM_MC-1:0]         oe_hold_q;
    logic                      asleep;
    logic                      wr;
    pprh_pkg::pprh_wr_type     wr_req;
    logic [31:0]               rd_data;
    logic                      rd_err;
    logic                      wr_err;
    logic                      pl_ok;
    logic                      pl_wr;
    logic [NUM_MC-1:0]         pl_val;
    logic [NUM_MC-1:0]         mc_next;

    pprh_por_timer #(
        .CYCLES   (POR_CYCLES)
    ) u_por (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_ce     (i_ce),
        .o_busy   (por_busy)
    );

    pprh_apb_slave u_apb (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_psel    (i_psel),
        .i_penable (i_penable),
        .i_pwrite  (i_pwrite),
        .i_paddr   (i_paddr),
        .i_pwdata  (i_pwdata),
        .i_rd_data (rd_data),
        .i_rd_err  (rd_err),
        .i_wr_err  (wr_err),
        .o_wr      (wr),
        .o_wr_req  (wr_req),
        .o_prdata  (o_prdata),
        .o_pready  (o_pready),
        .o_pslverr (o_pslverr)
    );

    assign asleep = sleep_en_q && i_sleep_hold_pin;
    assign pl_ok  = i_preload_hv && !lock_q && !asleep && !por_busy;
    assign pl_wr  = wr && (wr_req.addr == `PPRH_OFF_PL_VAL);
    assign pl_val = wr_req.wdata[NUM_MC-1:0];

    // Read decode; configuration readback blanks once locked
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (i_paddr)
            `PPRH_OFF_CTRL: begin
                rd_data[`PPRH_CTRL_SLEEP_EN] = sleep_en_q && !lock_q;
            end
            `PPRH_OFF_SLEW: begin
                rd_data[NUM_MC-1:0] = lock_q ? '0 : slew_q;
            end
            `PPRH_OFF_LOCK: begin
                rd_data[`PPRH_LOCK_SET] = lock_q;
            end
            `PPRH_OFF_STATUS: begin
                rd_data[3:0] = {lock_q, i_preload_hv, asleep, por_busy};
            end
            `PPRH_OFF_PL_MASK: begin
                rd_data[NUM_MC-1:0] = lock_q ? '0 : pl_mask_q;
            end
            `PPRH_OFF_PL_VAL: begin
                rd_data = 32'h0000_0000;
            end
            `PPRH_OFF_MC_STATE: begin
                rd_data[NUM_MC-1:0] = o_mc_q;
            end
            default: begin
                if (i_paddr >= `PPRH_OFF_SIG0 && i_paddr[1:0] == 2'b00
                    && i_paddr < 8'(`PPRH_OFF_SIG0 + 4 * `PPRH_SIG_WORDS)) begin
                    rd_data = sig_q[3'(i_paddr[7:2] - 6'(`PPRH_OFF_SIG0 >> 2))];
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    // Write refusal: bus writes are blocked in sleep, locked items are refused
    // Decided in the first access cycle, so the flag is registered before completion
    always_comb begin
        wr_err = 1'b0;
        if (asleep) begin
            wr_err = 1'b1;
        end else begin
            case (i_paddr)
                `PPRH_OFF_CTRL, `PPRH_OFF_SLEW, `PPRH_OFF_LOCK: begin
                    wr_err = 1'b0;
                end
                `PPRH_OFF_PL_MASK, `PPRH_OFF_PL_VAL: begin
                    wr_err = !pl_ok;
                end
                `PPRH_OFF_STATUS, `PPRH_OFF_MC_STATE: begin
                    wr_err = 1'b1;
                end
                default: begin
                    wr_err = !(i_paddr >= `PPRH_OFF_SIG0 && i_paddr[1:0] == 2'b00
                        && i_paddr < 8'(`PPRH_OFF_SIG0 + 4 * `PPRH_SIG_WORDS))
                        || lock_q;
                end
            endcase
        end
    end

    // Configuration bits
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sleep_en_q <= `PPRH_CTRL_RST;
            slew_q     <= NUM_MC'(`PPRH_SLEW_RST);
            pl_mask_q  <= '0;
        end else if (i_ce && wr) begin
            case (wr_req.addr)
                `PPRH_OFF_CTRL: begin
                    sleep_en_q <= wr_req.wdata[`PPRH_CTRL_SLEEP_EN];
                end
                `PPRH_OFF_SLEW: begin
                    slew_q <= wr_req.wdata[NUM_MC-1:0];
                end
                `PPRH_OFF_PL_MASK: begin
                    pl_mask_q <= wr_req.wdata[NUM_MC-1:0];
                end
                default: begin
                    pl_mask_q <= pl_mask_q;
                end
            endcase
        end
    end

    // Lock is write-one-to-set and acts from the next cycle on
    // Sticky until reset, so no bus sequence can undo it
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lock_q <= 1'b0;
        end else if (i_ce && wr && wr_req.addr == `PPRH_OFF_LOCK
                     && wr_req.wdata[`PPRH_LOCK_SET]) begin
            lock_q <= 1'b1;
        end
    end

    // User signature words
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int w = 0; w < `PPRH_SIG_WORDS; w++) begin
                sig_q[w] <= `PPRH_SIG_RST;
            end
        end else if (i_ce && wr && wr_req.addr >= `PPRH_OFF_SIG0) begin
            sig_q[3'(wr_req.addr[7:2] - 6'(`PPRH_OFF_SIG0 >> 2))] <= wr_req.wdata;
        end
    end

    // Macrocell register next value: preload overrides the array load
    // Forcing zero here keeps the pin stage low along with the register
    always_comb begin
        mc_next = o_mc_q;
        if (por_busy) begin
            mc_next = '0;
        end else if (pl_wr) begin
            mc_next = (o_mc_q & ~pl_mask_q) | (pl_val & pl_mask_q);
        end else if (i_mc_load) begin
            mc_next = i_mc_d;
        end
    end

    // Cleared through the power-up interval, frozen in sleep, no reset on wake
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mc_q <= '0;
        end else if (i_ce) begin
            if (por_busy) begin
                o_mc_q <= '0;
            end else if (!asleep) begin
                o_mc_q <= mc_next;
            end
        end
    end

    // Pin keepers: follow pins when awake, hold the last level in sleep
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            in_hold_q <= '0;
        end else if (i_ce && !asleep) begin
            in_hold_q <= i_pin_in;
        end
    end

    // Output stage per pin; slow edges cost one extra register stage
    for (genvar g = 0; g < NUM_MC; g++) begin : g_pin
        // Data path and edge-rate select
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                slow_q[g]      <= 1'b0;
                o_pin_out[g]   <= 1'b0;
                o_slew_fast[g] <= 1'b0;
            end else if (i_ce && !asleep) begin
                slow_q[g]      <= mc_next[g];
                o_pin_out[g]   <= slew_q[g] ? mc_next[g] : slow_q[g];
                o_slew_fast[g] <= slew_q[g];
            end
        end

        // Enable path; a pin floating at sleep entry keeps floating
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                oe_hold_q[g] <= 1'b0;
                o_pin_oe[g]  <= 1'b0;
            end else if (i_ce && !asleep) begin
                oe_hold_q[g] <= i_oe_req[g];
                o_pin_oe[g]  <= oe_hold_q[g];
            end
        end

        // Array input; the sleep pin's own lane reads low while it is the control
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                o_array_in[g] <= 1'b0;
            end else if (i_ce && !asleep) begin
                if (g == SLEEP_PIN_IDX && sleep_en_q) begin
                    o_array_in[g] <= 1'b0;
                end else begin
                    o_array_in[g] <= in_hold_q[g];
                end
            end
        end
    end

    // Status mirror for the board
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_status <= '{locked: 1'b0, preload_hv: 1'b0, asleep: 1'b0, por_busy: 1'b1};
        end else if (i_ce) begin
            o_status.locked     <= lock_q;
            o_status.preload_hv <= i_preload_hv;
            o_status.asleep     <= asleep;
            o_status.por_busy   <= por_busy;
        end
    end

endmodule : pprh_ctrl

`default_nettype wire

// ===== shared/pprh_cfg.svh
`ifndef PPRH_CFG_SVH
`define PPRH_CFG_SVH

// Register byte offsets
`define PPRH_OFF_CTRL      8'h00
`define PPRH_OFF_SLEW      8'h04
`define PPRH_OFF_LOCK      8'h08
`define PPRH_OFF_STATUS    8'h0C
`define PPRH_OFF_PL_MASK   8'h10
`define PPRH_OFF_PL_VAL    8'h14
`define PPRH_OFF_MC_STATE  8'h18
`define PPRH_OFF_SIG0      8'h20
`define PPRH_SIG_WORDS     5

// Field positions
`define PPRH_CTRL_SLEEP_EN 0
`define PPRH_LOCK_SET      0

// Reset values
`define PPRH_CTRL_RST      1'b0
`define PPRH_SLEW_RST      32'h0000_0000
`define PPRH_SIG_RST       32'h0000_0000

// Timing
`define PPRH_CLK_MHZ       40
`define PPRH_TPR_NS        10000
`define PPRH_TPR_CYC       ((`PPRH_TPR_NS * `PPRH_CLK_MHZ) / 1000)

`endif

// ===== shared/pprh_pkg.sv
package pprh_pkg;

    typedef struct packed {
        logic locked;
        logic preload_hv;
        logic asleep;
        logic por_busy;
    } pprh_status_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
    } pprh_wr_type;

endpackage : pprh_pkg

// ===== design/pprh_por_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pprh_cfg.svh"

module pprh_por_timer #(
    parameter int CYCLES = `PPRH_TPR_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    output logic      o_busy
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;

    // Busy from reset release until the interval has run out
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q  <= '0;
            o_busy <= 1'b1;
        end else if (i_ce && o_busy) begin
            if (cnt_q == CW'(CYCLES - 1)) begin
                o_busy <= 1'b0;
            end
            cnt_q <= cnt_q + CW'(1);
        end
    end

endmodule : pprh_por_timer

`default_nettype wire

// ===== design/pprh_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none

module pprh_apb_slave (
    input  wire logic                 i_clk,
    input  wire logic                 i_resetn,
    input  wire logic                 i_ce,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    input  wire logic [31:0]          i_rd_data,
    input  wire logic                 i_rd_err,
    input  wire logic                 i_wr_err,
    output logic                      o_wr,
    output pprh_pkg::pprh_wr_type     o_wr_req,
    output logic [31:0]               o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr
);

    logic access;

    assign access          = i_psel && i_penable;
    // Write lands on the completing edge, and only if it was not refused
    assign o_wr            = access && o_pready && i_pwrite && !o_pslverr;
    assign o_wr_req.addr   = i_paddr;
    assign o_wr_req.wdata  = i_pwdata;

    // One wait state keeps read data and the error flag registered
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            o_pready <= access && !o_pready;
            if (access && !o_pready) begin
                o_prdata  <= i_pwrite ? 32'h0000_0000 : i_rd_data;
                o_pslverr <= i_pwrite ? i_wr_err : i_rd_err;
            end else begin
                o_pslverr <= 1'b0;
            end
        end
    end

endmodule : pprh_apb_slave

`default_nettype wire

// ===== dv/pprh_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pprh_cfg.svh"

module pprh_ctrl_monitor #(
    parameter int NUM_MC = 32
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [7:0]              i_paddr,
    input  wire logic [31:0]             i_pwdata,
    input  wire logic                    i_sleep_hold_pin,
    input  wire logic                    i_preload_hv,
    input  wire logic                    o_pready,
    input  wire logic                    o_pslverr,
    input  wire logic [NUM_MC-1:0]       o_mc_q,
    input  wire logic [NUM_MC-1:0]       o_pin_out,
    input  wire logic [NUM_MC-1:0]       o_pin_oe,
    input  wire logic [NUM_MC-1:0]       o_array_in,
    input  wire logic [NUM_MC-1:0]       o_slew_fast,
    input  wire pprh_pkg::pprh_status_type o_status
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    logic wr_done;
    logic pl_wr;
    assign wr_done = i_psel && i_penable && i_pwrite && o_pready;
    // Status lags a cycle, so a status flag means the pin held through the previous edge
    assign pl_wr = wr_done && (i_paddr == `PPRH_OFF_PL_MASK || i_paddr == `PPRH_OFF_PL_VAL);

    a_por_clears_regs: assert property (o_status.por_busy |-> o_mc_q == '0)
        else $error("macrocell state not low during power-up reset");
    a_sleep_holds_state: assert property (
        o_status.asleep |-> $stable(o_mc_q) && $stable(o_pin_out))
        else $error("state or output moved during sleep");
    a_sleep_keeps_hiz: assert property (o_status.asleep |-> $stable(o_pin_oe))
        else $error("output enable moved during sleep");
    a_sleep_keeps_pins: assert property (o_status.asleep |-> $stable(o_array_in))
        else $error("pin keeper value moved during sleep");
    a_sleep_blocks_wr: assert property (
        o_status.asleep && i_sleep_hold_pin && wr_done |-> o_pslverr)
        else $error("write accepted during sleep");
    a_preload_needs_hv: assert property (pl_wr && !i_preload_hv |-> o_pslverr)
        else $error("preload accepted without high voltage");
    a_lock_blocks_pl: assert property (o_status.locked && pl_wr |-> o_pslverr)
        else $error("preload accepted while locked");
    // Register then output copy: the written value shows two edges after completion
    a_slew_follows_wr: assert property (
        wr_done && !o_pslverr && i_paddr == `PPRH_OFF_SLEW
        |-> ##2 o_slew_fast == NUM_MC'($past(i_pwdata, 2)))
        else $error("slew bits differ from written value");
endmodule : pprh_ctrl_monitor

bind pprh_ctrl pprh_ctrl_monitor #(.NUM_MC(NUM_MC)) u_mon (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_sleep_hold_pin(i_sleep_hold_pin), .i_preload_hv(i_preload_hv),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mc_q(o_mc_q), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_array_in(o_array_in), .o_slew_fast(o_slew_fast),
    .o_status(o_status));

`default_nettype wire

// ===== dv/pprh_board.sv
`timescale 1ns/1ps
`default_nettype none

module pprh_board (
    input  wire logic    i_clk,
    input  wire logic    i_por_busy,
    output var logic     o_sleep_hold_pin,
    output var logic     o_preload_hv,
    output var logic [31:0] o_pin_in,
    output var logic [31:0] o_mc_d,
    output var logic     o_mc_load,
    output var logic [31:0] o_oe_req
);
    initial begin
        o_sleep_hold_pin = 1'b0;
        o_preload_hv     = 1'b0;
        o_pin_in         = 32'h0000_0000;
        o_mc_d           = 32'h0000_0000;
        o_mc_load        = 1'b0;
        o_oe_req         = 32'h0000_0000;
    end

    task automatic set(input logic sl, input logic hv, input logic [31:0] pin,
                       input logic [31:0] oe);
        @(posedge i_clk);
        o_sleep_hold_pin <= sl;
        o_preload_hv     <= hv;
        o_pin_in         <= pin;
        o_oe_req         <= oe;
    endtask : set

    // No user clock edge until reset interval is over and data is set up
    task automatic load(input logic [31:0] v);
        @(posedge i_clk);
        while (i_por_busy) @(posedge i_clk);
        o_mc_d    <= v;
        o_mc_load <= 1'b1;
        @(posedge i_clk);
        o_mc_load <= 1'b0;
    endtask : load
endmodule : pprh_board

`default_nettype wire

// ===== dv/pprh_power_reset_hold_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pprh_cfg.svh"

module pprh_power_reset_hold_control_test;
    logic        clk, resetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        sleep, hv, mc_load;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, pin_in, mc_d, oe_req;
    logic [31:0] array_in, mc_q, pin_out, pin_oe, slew_fast;
    pprh_pkg::pprh_status_type status;
    int          err_total, n_tests;

    pprh_ctrl #(.NUM_MC(32), .SLEEP_PIN_IDX(0), .POR_CYCLES(8)) u_pprh_ctrl (
        .i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sleep_hold_pin(sleep), .i_preload_hv(hv), .i_pin_in(pin_in),
        .i_mc_d(mc_d), .i_mc_load(mc_load), .i_oe_req(oe_req), .o_array_in(array_in),
        .o_mc_q(mc_q), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
        .o_slew_fast(slew_fast), .o_status(status));

    pprh_board u_board (
        .i_clk(clk), .i_por_busy(status.por_busy), .o_sleep_hold_pin(sleep),
        .o_preload_hv(hv), .o_pin_in(pin_in), .o_mc_d(mc_d), .o_mc_load(mc_load),
        .o_oe_req(oe_req));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    task automatic conclude();
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Data is compared only on good answers; error data is undefined
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic ee);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        chk({31'h0, pslverr}, {31'h0, ee});
        if (!w && !ee) chk(prdata, exp);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        err_total = 0;
        n_tests = 0;
        resetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (20) @(posedge clk);
        chk(mc_q, 32'h0000_0000);
        resetn <= 1'b1;
        while (status.por_busy) @(posedge clk);
        #1 chk({28'h0, status}, 32'h0000_0000);
        apb(0, `PPRH_OFF_CTRL, 0, 32'h0000_0000, 0);
        apb(0, `PPRH_OFF_SLEW, 0, 32'h0000_0000, 0);
        apb(1, `PPRH_OFF_SLEW, 32'h0000_0001, 0, 0);
        u_board.load(32'h0000_0003);
        #1 chk(pin_out, 32'h0000_0001);
        @(posedge clk);
        #1 chk(pin_out, 32'h0000_0003);
        u_board.set(1, 0, 32'hFFFF_FFFF, 32'h0000_00F0);
        repeat (4) @(posedge clk);
        #1 chk({31'h0, status.asleep}, 32'h0000_0000);
        chk(array_in, 32'hFFFF_FFFF);
        u_board.set(0, 0, 32'hFFFF_FFFF, 32'h0000_00F0);
        apb(1, `PPRH_OFF_CTRL, 32'h0000_0001, 0, 0);
        repeat (3) @(posedge clk);
        #1 chk(array_in, 32'hFFFF_FFFE);
        u_board.set(1, 0, 32'h0000_0000, 32'h0000_000F);
        repeat (3) @(posedge clk);
        u_board.load(32'h0000_0055);
        #1 chk(mc_q, 32'h0000_0003);
        chk(pin_oe, 32'h0000_00F0);
        chk(array_in, 32'hFFFF_FFFE);
        apb(1, `PPRH_OFF_SIG0, 32'h0000_0077, 0, 1);
        apb(0, `PPRH_OFF_SIG0, 0, 32'h0000_0000, 0);
        u_board.set(0, 0, 32'hFFFF_FFFF, 32'h0000_00F0);
        repeat (3) @(posedge clk);
        #1 chk(mc_q, 32'h0000_0003);
        chk(pin_out, 32'h0000_0003);
        u_board.load(32'h0000_0005);
        #1 chk(mc_q, 32'h0000_0005);
        // Clock enable low: a load must not reach the registers
        @(posedge clk);
        ce <= 1'b0;
        u_board.load(32'h0000_000F);
        #1 chk(mc_q, 32'h0000_0005);
        @(posedge clk);
        ce <= 1'b1;
        apb(1, `PPRH_OFF_PL_MASK, 32'h0000_00F0, 0, 1);
        u_board.set(0, 1, 32'hFFFF_FFFF, 32'h0000_00F0);
        apb(1, `PPRH_OFF_PL_MASK, 32'h0000_00F0, 0, 0);
        apb(1, `PPRH_OFF_PL_VAL, 32'h0000_00A0, 0, 0);
        #1 chk(mc_q, 32'h0000_00A5);
        apb(1, `PPRH_OFF_PL_VAL, 32'h0000_0050, 0, 0);
        #1 chk(mc_q, 32'h0000_0055);
        apb(1, `PPRH_OFF_SIG0, 32'h1234_5678, 0, 0);
        apb(1, `PPRH_OFF_LOCK, 32'h0000_0001, 0, 0);
        apb(0, `PPRH_OFF_CTRL, 0, 32'h0000_0000, 0);
        apb(1, `PPRH_OFF_PL_VAL, 32'h0000_0000, 0, 1);
        apb(1, `PPRH_OFF_SIG0, 32'h0000_0000, 0, 1);
        apb(0, `PPRH_OFF_SIG0, 0, 32'h1234_5678, 0);
        apb(0, 8'h40, 0, 0, 1);
        #1 chk({28'h0, status}, 32'h0000_000C);
        conclude();
    end

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        conclude();
    end
endmodule : pprh_power_reset_hold_control_test

`default_nettype wire
